/* File: nfs_cfg.svh */
/*
 * nfs_cfg.svh: offsets, field positions, reset values, command codes and
 * timing counts of the parallel nor flash host controller.
 * assumes a 50 MHz clock and a 21-bit word address on the flash.
 */
`ifndef NFS_CFG_SVH
`define NFS_CFG_SVH

// register byte offsets on the wishbone slave
`define NFS_OFS_CTRL 8'h00
`define NFS_OFS_ADDR 8'h04
`define NFS_OFS_WDATA 8'h08
`define NFS_OFS_STATUS 8'h0c
`define NFS_OFS_RDATA 8'h10

// control register fields
`define NFS_CTRL_CMD_LSB 0
`define NFS_CTRL_WPN_BIT 8
`define NFS_WPN_RESET 1'b1

// status register fields
`define NFS_ST_BUSY 0
`define NFS_ST_DONE 1
`define NFS_ST_ABORT 2
`define NFS_ST_REFUSED 3
`define NFS_ST_TOG6 4
`define NFS_ST_TOG2 5
`define NFS_ST_READY 6
`define NFS_ST_WPN 7

// flash command words
`define NFS_UNLOCK_A1 21'h000555
`define NFS_UNLOCK_D1 16'h00aa
`define NFS_UNLOCK_A2 21'h0002aa
`define NFS_UNLOCK_D2 16'h0055
`define NFS_CMD_PROG 16'h00a0
`define NFS_CMD_ERASE 16'h0080
`define NFS_CMD_SECTOR 16'h0050
`define NFS_CMD_BLOCK 16'h0030
`define NFS_CMD_CHIP 16'h0010
`define NFS_CMD_SUSPEND 16'h00b0
`define NFS_CMD_RESUME 16'h0030
`define NFS_CMD_CFI 16'h0098
`define NFS_CFI_SHORT_A 21'h000055
`define NFS_CMD_ID 16'h0090
`define NFS_CMD_EXIT 16'h00f0
`define NFS_ID_MAKER_A 21'h000000
`define NFS_ID_DEVICE_A 21'h000001

// toggle and suspend toggle positions in a status word
`define NFS_DQ_TOG 6
`define NFS_DQ_SUSP 2

// timing in ns and the derived cycle counts
`define NFS_CLK_MHZ 50
`define NFS_CYC_UP(ns) ((((ns) * `NFS_CLK_MHZ) + 999) / 1000)
`define NFS_GLITCH_NS 5
`define NFS_WE_LOW_NS 40
`define NFS_SETUP_NS 20
`define NFS_HOLD_NS 30
`define NFS_ACCESS_NS 90
`define NFS_SYNC_CYC 2
`define NFS_RST_PULSE_NS 500
`define NFS_RST_RECOV_NS 1000
`define NFS_WE_CYC `NFS_CYC_UP(`NFS_WE_LOW_NS)
`define NFS_GLITCH_CYC `NFS_CYC_UP(`NFS_GLITCH_NS)
`define NFS_SETUP_CYC `NFS_CYC_UP(`NFS_SETUP_NS)
`define NFS_HOLD_CYC `NFS_CYC_UP(`NFS_HOLD_NS)
`define NFS_ACC_CYC (`NFS_CYC_UP(`NFS_ACCESS_NS) + `NFS_SYNC_CYC)
`define NFS_RST_CYC `NFS_CYC_UP(`NFS_RST_PULSE_NS)
`define NFS_REC_CYC `NFS_CYC_UP(`NFS_RST_RECOV_NS)

`endif

/* File: nfs_pkg.sv */
/*
 * nfs_pkg: types of the nor flash host controller.
 * assumes nothing beyond a systemverilog compiler.
 */
package nfs_pkg;

  typedef enum logic [3:0] {
    NFS_NOP = 4'h0,
    NFS_READ = 4'h1,
    NFS_PROGRAM = 4'h2,
    NFS_SECTOR_ERASE = 4'h3,
    NFS_BLOCK_ERASE = 4'h4,
    NFS_CHIP_ERASE = 4'h5,
    NFS_SUSPEND = 4'h6,
    NFS_RESUME = 4'h7,
    NFS_CFI_ENTRY = 4'h8,
    NFS_CFI_SHORT = 4'h9,
    NFS_ID_ENTRY = 4'ha,
    NFS_ID_EXIT = 4'hb,
    NFS_HW_RESET = 4'hc,
    NFS_STATUS = 4'hd
  } nfs_cmd_e;

  typedef enum logic [2:0] {
    NFS_S_IDLE = 3'h0,
    NFS_S_STEP = 3'h1,
    NFS_S_WAIT = 3'h2,
    NFS_S_POLL = 3'h3,
    NFS_S_PWAIT = 3'h4,
    NFS_S_RST = 3'h5,
    NFS_S_REC = 3'h6
  } nfs_state_e;

  typedef enum logic [1:0] {
    NFS_E_IDLE = 2'h0,
    NFS_E_SET = 2'h1,
    NFS_E_STB = 2'h2,
    NFS_E_REC = 2'h3
  } nfs_estate_e;

  typedef struct packed {
    logic [20:0] a;
    logic [15:0] d;
  } nfs_step_s;

endpackage

/* File: nfs_cyc_if.sv */
/*
 * nfs_cyc_if: one flash bus cycle request and its answer.
 * assumes the sequencer and the cycle engine share one clock.
 */
`timescale 1ns/1ns
interface nfs_cyc_if;
  logic req;
  logic wr;
  logic [20:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

/* File: nfs_cyc.sv */
/*
 * nfs_cyc: runs one asynchronous read or write cycle on the flash pins.
 * assumes req is a one-cycle pulse and no new req comes before done.
 */
`timescale 1ns/1ns
`include "nfs_cfg.svh"
module nfs_cyc
  import nfs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request
  nfs_cyc_if.eng cyc,
  // flash pins
  output logic [20:0] addr_o,
  output logic [15:0] dq_o,
  output logic dq_oe_n_o,
  input wire logic [15:0] dq_i,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o
);
  localparam logic [7:0] WE_CYC = 8'((`NFS_WE_CYC > `NFS_GLITCH_CYC) ?
                                     `NFS_WE_CYC : `NFS_GLITCH_CYC + 1);
  nfs_estate_e st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic [20:0] addr_d;
  logic [15:0] dq_d, rdata_q, rdata_d;
  logic dq_oe_n_d, ce_n_d, oe_n_d, we_n_d, done_q, done_d;
  logic [15:0] dq_s1_q, dq_s2_q;

  assign cyc.done = done_q;
  assign cyc.rdata = rdata_q;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    addr_d = addr_o;
    dq_d = dq_o;
    dq_oe_n_d = dq_oe_n_o;
    ce_n_d = ce_n_o;
    oe_n_d = oe_n_o;
    we_n_d = we_n_o;
    rdata_d = rdata_q;
    done_d = 1'b0;
    case (st_q)
      NFS_E_IDLE:
      begin
        if (cyc.req)
        begin
          // address stays put for the whole cycle, status reads included
          addr_d = cyc.addr;
          dq_d = cyc.wdata;
          wr_d = cyc.wr;
          dq_oe_n_d = ~cyc.wr;
          ce_n_d = 1'b0;
          cnt_d = 8'(`NFS_SETUP_CYC);
          st_d = NFS_E_SET;
        end
      end
      NFS_E_SET:
      begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01)
        begin
          // write strobe only with the output gate high
          we_n_d = ~wr_q;
          oe_n_d = wr_q;
          // strobe kept well above the glitch filter width
          cnt_d = wr_q ? WE_CYC : 8'(`NFS_ACC_CYC);
          st_d = NFS_E_STB;
        end
      end
      NFS_E_STB:
      begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01)
        begin
          we_n_d = 1'b1;
          oe_n_d = 1'b1;
          if (!wr_q)
          begin
            rdata_d = dq_s2_q;
          end
          cnt_d = 8'(`NFS_HOLD_CYC);
          st_d = NFS_E_REC;
        end
      end
      NFS_E_REC:
      begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01)
        begin
          // deselect ends each read, so the toggle bit advances per read
          ce_n_d = 1'b1;
          dq_oe_n_d = 1'b1;
          done_d = 1'b1;
          st_d = NFS_E_IDLE;
        end
      end
      default:
      begin
        st_d = NFS_E_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    dq_s1_q <= dq_i;
    dq_s2_q <= dq_s1_q;
    if (rst_i)
    begin
      st_q <= NFS_E_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      addr_o <= 21'h000000;
      dq_o <= 16'h0000;
      dq_oe_n_o <= 1'b1;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      rdata_q <= 16'h0000;
      done_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      addr_o <= addr_d;
      dq_o <= dq_d;
      dq_oe_n_o <= dq_oe_n_d;
      ce_n_o <= ce_n_d;
      oe_n_o <= oe_n_d;
      we_n_o <= we_n_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
    end
  end
endmodule

/* File: nfs_host.sv */
/*
 * nfs_host: wishbone-driven host for an x16 asynchronous nor flash:
 * unlock sequences, program, erase, suspend, query and id modes,
 * toggle polling, boot lock and hardware reset of the flash.
 * assumes a classic wishbone master and a flash wired to the pins;
 * flash inputs are asynchronous and resynchronised here.
 */
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "nfs_cfg.svh"
module nfs_host
  import nfs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // flash pins
  output logic [20:0] flash_addr_o,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe_n_o,
  input wire logic [15:0] flash_dq_i,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic flash_wp_n_o,
  output logic flash_rst_n_o,
  input wire logic op_busy_out_n_i
);
  nfs_cyc_if cyc ();
  nfs_state_e st_q, st_d;
  nfs_cmd_e cmd_q, cmd_d;
  logic [2:0] step_q, step_d;
  logic [15:0] cnt_q, cnt_d;
  logic [20:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic busy_q, busy_d, done_q, done_d, abort_q, abort_d, ref_q, ref_d;
  logic tog6_q, tog6_d, tog2_q, tog2_d, prev_v_q, prev_v_d;
  logic [15:0] prev_q, prev_d;
  logic wp_n_q, wp_n_d, rst_n_q, rst_n_d, req_q, req_d, wr_q, wr_d;
  logic ack_d;
  logic [31:0] dat_d;
  logic rdy_s1_q, rdy_s2_q;
  logic acc, wr_ctrl;
  nfs_step_s cur;

  // cycles in each command's write sequence
  function automatic logic [2:0] seq_len(input nfs_cmd_e c);
    case (c)
      NFS_PROGRAM: seq_len = 3'h4;
      NFS_SECTOR_ERASE, NFS_BLOCK_ERASE, NFS_CHIP_ERASE: seq_len = 3'h6;
      NFS_CFI_ENTRY, NFS_ID_ENTRY: seq_len = 3'h3;
      NFS_SUSPEND, NFS_RESUME, NFS_CFI_SHORT, NFS_ID_EXIT: seq_len = 3'h1;
      default: seq_len = 3'h0;
    endcase
  endfunction

  // address and data of write k; upper data byte low except in the program data word
  function automatic nfs_step_s seq_step(input nfs_cmd_e c, input logic [2:0] k,
                                         input logic [20:0] a, input logic [15:0] d);
    nfs_step_s s;
    s.a = `NFS_UNLOCK_A1;
    s.d = `NFS_UNLOCK_D1;
    if (k == 3'h1 || k == 3'h4)
    begin
      s.a = `NFS_UNLOCK_A2;
      s.d = `NFS_UNLOCK_D2;
    end
    else if (k == 3'h2)
    begin
      s.d = (c == NFS_PROGRAM) ? `NFS_CMD_PROG :
            (c == NFS_CFI_ENTRY) ? `NFS_CMD_CFI :
            (c == NFS_ID_ENTRY) ? `NFS_CMD_ID : `NFS_CMD_ERASE;
    end
    else if (k == 3'h3 && c == NFS_PROGRAM)
    begin
      s.a = a;
      s.d = d;
    end
    else if (k == 3'h5)
    begin
      s.a = (c == NFS_CHIP_ERASE) ? `NFS_UNLOCK_A1 : a;
      s.d = (c == NFS_SECTOR_ERASE) ? `NFS_CMD_SECTOR :
            (c == NFS_BLOCK_ERASE) ? `NFS_CMD_BLOCK : `NFS_CMD_CHIP;
    end
    if (k == 3'h0)
    begin
      case (c)
        NFS_SUSPEND: s.d = `NFS_CMD_SUSPEND;
        NFS_RESUME: s.d = `NFS_CMD_RESUME;
        NFS_ID_EXIT: s.d = `NFS_CMD_EXIT;
        NFS_CFI_SHORT:
        begin
          s.a = `NFS_CFI_SHORT_A;
          s.d = `NFS_CMD_CFI;
        end
        default: s.d = s.d;
      endcase
      if (c == NFS_SUSPEND || c == NFS_RESUME || c == NFS_ID_EXIT)
      begin
        s.a = a;
      end
    end
    return s;
  endfunction

  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl = acc && wb_we_i && wb_sel_i[0] && wb_adr_i == `NFS_OFS_CTRL;
  assign cur = seq_step(cmd_q, step_q, addr_q, wdata_q);
  assign cyc.req = req_q;
  assign cyc.wr = wr_q;
  assign cyc.addr = (st_q == NFS_S_STEP || st_q == NFS_S_WAIT) ? cur.a : addr_q;
  assign cyc.wdata = cur.d;

  always_comb
  begin
    st_d = st_q;
    cmd_d = cmd_q;
    step_d = step_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    busy_d = busy_q;
    done_d = done_q;
    abort_d = abort_q;
    ref_d = ref_q;
    tog6_d = tog6_q;
    tog2_d = tog2_q;
    prev_v_d = prev_v_q;
    prev_d = prev_q;
    wp_n_d = wp_n_q;
    rst_n_d = rst_n_q;
    req_d = 1'b0;
    wr_d = wr_q;
    ack_d = acc;
    dat_d = 32'h00000000;
    if (acc && !wb_we_i)
    begin
      case (wb_adr_i)
        `NFS_OFS_CTRL: dat_d = {23'h000000, wp_n_q, 4'h0, cmd_q};
        `NFS_OFS_ADDR: dat_d = {11'h000, addr_q};
        `NFS_OFS_WDATA: dat_d = {16'h0000, wdata_q};
        // ready level and suspend toggle let software tell suspend apart
        `NFS_OFS_STATUS: dat_d = {24'h000000, wp_n_q, rdy_s2_q, tog2_q, tog6_q,
                                  ref_q, abort_q, done_q, busy_q};
        `NFS_OFS_RDATA: dat_d = {16'h0000, rdata_q};
        default: dat_d = 32'h00000000;
      endcase
    end
    if (acc && wb_we_i && !busy_q)
    begin
      if (wb_adr_i == `NFS_OFS_ADDR)
      begin
        addr_d = wb_dat_i[20:0];
      end
      if (wb_adr_i == `NFS_OFS_WDATA)
      begin
        wdata_d = wb_dat_i[15:0];
      end
    end
    case (st_q)
      NFS_S_IDLE:
      begin
        if (wr_ctrl)
        begin
          // boot lock level is software's; open after reset
          wp_n_d = wb_dat_i[`NFS_CTRL_WPN_BIT];
          cmd_d = nfs_cmd_e'(wb_dat_i[`NFS_CTRL_CMD_LSB +: 4]);
          step_d = 3'h0;
          prev_v_d = 1'b0;
          if (cmd_d != NFS_NOP)
          begin
            done_d = 1'b0;
            ref_d = 1'b0;
            busy_d = 1'b1;
            if (cmd_d == NFS_HW_RESET)
            begin
              // work cut short by reset must be issued again by software
              abort_d = !rdy_s2_q;
              rst_n_d = 1'b0;
              cnt_d = 16'(`NFS_RST_CYC);
              st_d = NFS_S_RST;
            end
            else if (cmd_d == NFS_ID_EXIT && !rdy_s2_q)
            begin
              // the flash would ignore it anyway; say so instead
              ref_d = 1'b1;
              done_d = 1'b1;
              busy_d = 1'b0;
            end
            else if (seq_len(cmd_d) == 3'h0)
            begin
              st_d = NFS_S_POLL;
            end
            else
            begin
              st_d = NFS_S_STEP;
            end
          end
        end
      end
      NFS_S_STEP:
      begin
        // full unlock sequence before every program or erase
        req_d = 1'b1;
        wr_d = 1'b1;
        st_d = NFS_S_WAIT;
      end
      NFS_S_WAIT:
      begin
        if (cyc.done)
        begin
          step_d = step_q + 3'h1;
          st_d = NFS_S_STEP;
          if (step_q == seq_len(cmd_q) - 3'h1)
          begin
            // polling starts only after the last strobe of the sequence
            st_d = (cmd_q == NFS_PROGRAM || cmd_q == NFS_SUSPEND ||
                    seq_len(cmd_q) == 3'h6) ? NFS_S_POLL : NFS_S_IDLE;
            busy_d = (st_d == NFS_S_POLL);
            done_d = !busy_d;
          end
        end
      end
      NFS_S_POLL:
      begin
        req_d = 1'b1;
        wr_d = 1'b0;
        st_d = NFS_S_PWAIT;
      end
      NFS_S_PWAIT:
      begin
        if (cyc.done)
        begin
          rdata_d = cyc.rdata;
          prev_d = cyc.rdata;
          prev_v_d = 1'b1;
          st_d = NFS_S_POLL;
          if (prev_v_q)
          begin
            // differing toggles mean busy; held 1 means suspended sector
            tog6_d = cyc.rdata[`NFS_DQ_TOG] ^ prev_q[`NFS_DQ_TOG];
            tog2_d = cyc.rdata[`NFS_DQ_SUSP] ^ prev_q[`NFS_DQ_SUSP];
          end
          // two equal toggle reads end the wait; the second of them is kept as the read data
          if (cmd_q == NFS_READ || (prev_v_q && (cmd_q == NFS_STATUS ||
              cyc.rdata[`NFS_DQ_TOG] == prev_q[`NFS_DQ_TOG])))
          begin
            st_d = NFS_S_IDLE;
            busy_d = 1'b0;
            done_d = 1'b1;
          end
        end
      end
      NFS_S_RST:
      begin
        cnt_d = cnt_q - 16'h0001;
        if (cnt_q == 16'h0001)
        begin
          // held the minimum pulse, then recovery before any read
          rst_n_d = 1'b1;
          cnt_d = 16'(`NFS_REC_CYC);
          st_d = NFS_S_REC;
        end
      end
      NFS_S_REC:
      begin
        cnt_d = cnt_q - 16'h0001;
        if (cnt_q == 16'h0001)
        begin
          st_d = NFS_S_IDLE;
          busy_d = 1'b0;
          done_d = 1'b1;
        end
      end
      default:
      begin
        st_d = NFS_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    // ready/busy is open drain from the flash: resynchronise first
    rdy_s1_q <= op_busy_out_n_i;
    rdy_s2_q <= rdy_s1_q;
    if (rst_i)
    begin
      st_q <= NFS_S_IDLE;
      cmd_q <= NFS_NOP;
      step_q <= 3'h0;
      cnt_q <= 16'h0000;
      addr_q <= 21'h000000;
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
      ref_q <= 1'b0;
      tog6_q <= 1'b0;
      tog2_q <= 1'b0;
      prev_v_q <= 1'b0;
      prev_q <= 16'h0000;
      wp_n_q <= `NFS_WPN_RESET;
      rst_n_q <= 1'b1;
      req_q <= 1'b0;
      wr_q <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      step_q <= step_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      busy_q <= busy_d;
      done_q <= done_d;
      abort_q <= abort_d;
      ref_q <= ref_d;
      tog6_q <= tog6_d;
      tog2_q <= tog2_d;
      prev_v_q <= prev_v_d;
      prev_q <= prev_d;
      wp_n_q <= wp_n_d;
      rst_n_q <= rst_n_d;
      req_q <= req_d;
      wr_q <= wr_d;
      wb_ack_o <= ack_d;
      wb_dat_o <= dat_d;
    end
  end

  assign flash_wp_n_o = wp_n_q;
  assign flash_rst_n_o = rst_n_q;

  nfs_cyc u_cyc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc(cyc.eng),
    .addr_o(flash_addr_o),
    .dq_o(flash_dq_o),
    .dq_oe_n_o(flash_dq_oe_n_o),
    .dq_i(flash_dq_i),
    .ce_n_o(flash_ce_n_o),
    .oe_n_o(flash_oe_n_o),
    .we_n_o(flash_we_n_o)
  );
endmodule

/* File: nfs_host_chk.sv */
/*
 * nfs_host_chk: assertions on the wishbone handshake and flash pins.
 * assumes it is bound to nfs_host, one clock, synchronous reset.
 */
`timescale 1ns/1ns
module nfs_host_chk (
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // flash pins
  input wire logic [20:0] flash_addr_o,
  input wire logic flash_dq_oe_n_o,
  input wire logic flash_ce_n_o,
  input wire logic flash_oe_n_o,
  input wire logic flash_we_n_o,
  input wire logic flash_rst_n_o
);
  logic [7:0] rcnt_q;
  logic [7:0] rcnt_d;
  // saturates so a long reset pulse cannot wrap round into a fail
  always_comb
  begin
    rcnt_d = (rst_i || flash_rst_n_o) ? 8'h00 : rcnt_q + {7'h00, rcnt_q != 8'hff};
  end
  always_ff @(posedge clk_i)
  begin
    rcnt_q <= rcnt_d;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_write_gate: assert property (!flash_we_n_o |->
    !flash_ce_n_o && flash_oe_n_o && !flash_dq_oe_n_o)
    else $error("write strobe outside a write cycle");
  a_we_width: assert property ($fell(flash_we_n_o) |=>
    !flash_we_n_o ##1 flash_we_n_o) else $error("write strobe width wrong");
  a_addr_held: assert property (!flash_ce_n_o && !$past(flash_ce_n_o) |->
    $stable(flash_addr_o)) else $error("address moved in a cycle");
  a_no_contend: assert property (!flash_oe_n_o |-> flash_dq_oe_n_o)
    else $error("host drives data during read");
  a_read_width: assert property ($fell(flash_oe_n_o) |->
    !flash_oe_n_o [*7] ##1 flash_oe_n_o) else $error("read gate width wrong");
  a_ce_gap: assert property ($rose(flash_ce_n_o) |=> flash_ce_n_o)
    else $error("cycles too close");
  a_rst_pulse: assert property ($rose(flash_rst_n_o) |-> rcnt_q >= 8'h19)
    else $error("flash reset pulse short");
  a_rst_quiet: assert property (!flash_rst_n_o |-> flash_ce_n_o && flash_we_n_o)
    else $error("flash access during reset");
  c_write: cover property ($fell(flash_we_n_o));
  c_read: cover property ($fell(flash_oe_n_o));
  c_reset: cover property ($rose(flash_rst_n_o));
endmodule

bind nfs_host nfs_host_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .flash_addr_o(flash_addr_o),
  .flash_dq_oe_n_o(flash_dq_oe_n_o), .flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o),
  .flash_we_n_o(flash_we_n_o), .flash_rst_n_o(flash_rst_n_o));

/* File: nfs_flash_mdl.sv */
/*
 * nfs_flash_mdl: behavioural x16 nor flash, bottom boot variant, 4k words kept.
 * assumes strobes from a host; ready pin has a pull-up on the board.
 */
`timescale 1ns/1ns
module nfs_flash_mdl #(
  parameter logic [15:0] MAKER_ID = 16'h00a5,
  parameter logic [15:0] DEVICE_ID = 16'h5a01,
  parameter logic [15:0] CFI_WORD = 16'h0051,
  parameter int PROG_NS = 2000,
  parameter int ERASE_NS = 6000,
  parameter int RST_NS = 480
) (
  // pins from the host
  input wire logic [20:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic wp_n_i,
  input wire logic rst_n_i,
  // pins to the host
  output logic [15:0] dq_o,
  output logic busy_n_o
);
  logic [15:0] mem [0:4095];
  logic [15:0] out_q = 16'h0000;
  logic [15:0] pd = 16'h0000;
  logic tog = 1'b0;
  logic ers = 1'b0;
  logic id_m = 1'b0;
  logic cfi_m = 1'b0;
  logic busy = 1'b0;
  int st = 0;
  time end_t = 0;
  time fall_t = 0;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  always #10 busy = ($time < end_t);
  assign busy_n_o = !busy;
  // a released bus shows the inverse of the last word, never a stale copy
  assign dq_o = (!ce_n_i && !oe_n_i) ? out_q : ~out_q;
  function automatic bit locked(input logic [20:0] a);
    return !wp_n_i && a < 21'h002000;
  endfunction
  always @(negedge we_n_i) fall_t = $time;
  // commands are ignored while busy
  always @(posedge we_n_i)
  begin
    if (!ce_n_i && oe_n_i && $time - fall_t >= 5 && !busy)
    begin
      if (dq_i[7:0] == 8'hf0)
      begin
        id_m = 0; cfi_m = 0; st = 0;
      end
      else if (st == 0 && addr_i == 21'h55 && dq_i[7:0] == 8'h98) cfi_m = 1;
      else case (st)
        0, 4: st = (addr_i == 21'h555 && dq_i[7:0] == 8'haa) ? st + 1 : 0;
        1, 5: st = (addr_i == 21'h2aa && dq_i[7:0] == 8'h55) ? st + 1 : 0;
        2:
        begin
          st = dq_i[7:0] == 8'ha0 ? 3 : dq_i[7:0] == 8'h80 ? 4 : 0;
          cfi_m |= dq_i[7:0] == 8'h98;
          id_m |= dq_i[7:0] == 8'h90;
        end
        3:
        begin
          st = 0;
          if (!locked(addr_i))
          begin
            pd = dq_i; mem[addr_i[11:0]] = dq_i; ers = 0; end_t = $time + PROG_NS;
          end
        end
        6:
        begin
          st = 0;
          if (dq_i[7:0] == 8'h10 ? wp_n_i : !locked(addr_i))
          begin
            for (int i = 0; i < 4096; i++)
              if (dq_i[7:0] != 8'h50 || i[11] == addr_i[11]) mem[i] = 16'hffff;
            ers = 1; end_t = $time + ERASE_NS;
          end
        end
        default: st = 0;
      endcase
    end
  end
  // one toggle step per read while busy, on the falling output gate
  always @(negedge oe_n_i)
  begin
    if (!ce_n_i)
    begin
      if (busy)
      begin
        tog = ~tog;
        out_q = {8'h00, ers ? 1'b0 : ~pd[7], tog, 3'b000, ers & tog, 2'b00};
      end
      else if (id_m) out_q = addr_i[0] ? DEVICE_ID : MAKER_ID;
      else if (cfi_m) out_q = CFI_WORD;
      else out_q = mem[addr_i[11:0]];
    end
  end
  always @(negedge rst_n_i)
  begin
    #(RST_NS);
    if (!rst_n_i)
    begin
      end_t = 0; st = 0; id_m = 0; cfi_m = 0;
    end
  end
endmodule

/* File: test_nfs_host.sv */
/*
 * test_nfs_host: self-checking bench of nfs_host against a flash model.
 * assumes a 50 MHz clock; ids are arbitrary bench values.
 */
`timescale 1ns/1ns
module test_nfs_host;
  localparam logic [15:0] MAKER = 16'h00a5; // arbitrary
  localparam logic [15:0] DEV = 16'h5a01; // arbitrary
  localparam logic [15:0] CFIW = 16'h0051;
  logic clk_i, rst_i, cyc, stb, we, wp, chk_on, ack, ce_n, oe_n, we_n, wp_n, rst_n, rdy_n;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dat_o;
  logic [20:0] fa;
  logic [15:0] fdo, fdi, d0;
  logic [63:0] mon_e;
  logic [63:0] q[$];
  logic [3:0] oth [6] = '{4'h6, 4'h7, 4'hd, 4'h4, 4'h5, 4'hc};
  // open-drain ready of a second device sharing the pulled-up line
  logic oth_rdy_n;
  logic [3:0] st_e;
  int err_count = 0, n_tests = 0, cyc_n = 0, seed = 32'h71d5;
  nfs_host i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .flash_addr_o(fa), .flash_dq_o(fdo), .flash_dq_oe_n_o(), .flash_dq_i(fdi),
    .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_wp_n_o(wp_n),
    .flash_rst_n_o(rst_n), .op_busy_out_n_i(rdy_n & oth_rdy_n));
  nfs_flash_mdl #(.MAKER_ID(MAKER), .DEVICE_ID(DEV), .CFI_WORD(CFIW)) i_flash (.addr_i(fa),
    .dq_i(fdo), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .wp_n_i(wp_n), .rst_n_i(rst_n),
    .dq_o(fdi), .busy_n_o(rdy_n));
  initial
  begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  task give_verdict;
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 60000)
    begin
      err_count++;
      give_verdict;
    end
  end
  // oldest note is matched against the read data at its ack
  always @(posedge clk_i)
  begin
    if (chk_on && ack === 1'b1)
    begin
      mon_e = q.pop_front();
      n_tests++;
      if ((dat_o & mon_e[63:32]) !== mon_e[31:0])
      begin
        $display("wrong value wb_dat_o expected %h seen %h", mon_e[31:0], dat_o & mon_e[63:32]);
        err_count++;
      end
    end
  end
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    r = dat_o;
    cyc <= 0; stb <= 0;
  endtask
  task expect_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    q.push_back({m, e & m});
    chk_on <= 1;
    wb(0, a, 32'h0, r);
    chk_on <= 0;
  endtask
  // start a command and wait for it to finish, then check the low status bits against st_e
  task run(input logic [3:0] c, input logic [20:0] a, input logic [15:0] d);
    logic [31:0] r;
    wb(1, 8'h04, {11'h0, a}, r);
    wb(1, 8'h08, {16'h0, d}, r);
    wb(1, 8'h00, {23'h0, wp, 4'h0, c}, r);
    do wb(0, 8'h0c, 32'h0, r); while (r[0] !== 1'b0);
    expect_rd(8'h0c, 32'h0f, {28'h0, st_e});
  endtask
  task read_chk(input logic [20:0] a, input logic [15:0] e);
    run(4'h1, a, 16'h0);
    expect_rd(8'h10, 32'hffff, {16'h0, e});
  endtask
  initial
  begin
    rst_i = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 4'hf; dat = 0; wp = 1; chk_on = 0;
    oth_rdy_n = 1;
    st_e = 4'h2;
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    expect_rd(8'h00, 32'h10f, 32'h100);
    expect_rd(8'h0c, 32'hc1, 32'hc0);
    expect_rd(8'h20, 32'hffffffff, 32'h0);
    d0 = $random(seed);
    run(4'h2, 21'h004345, d0);
    read_chk(21'h004345, d0);
    run(4'h3, 21'h004345, 16'h0);
    read_chk(21'h004345, 16'hffff);
    for (int c = 8; c <= 10; c++)
    begin
      run(c[3:0], 21'h0, 16'h0);
      read_chk(21'h0, c == 10 ? MAKER : CFIW);
      read_chk(21'h1, c == 10 ? DEV : CFIW);
      run(4'hb, 21'h0, 16'h0);
      read_chk(21'h004345, 16'hffff);
    end
    wp = 0;
    run(4'h2, 21'h000010, d0);
    read_chk(21'h000010, 16'hffff);
    expect_rd(8'h0c, 32'h80, 32'h0);
    wp = 1;
    run(4'h2, 21'h000010, d0);
    read_chk(21'h000010, d0);
    foreach (oth[i]) run(oth[i], 21'h000010, 16'h0);
    read_chk(21'h000010, 16'hffff);
    // shared ready line held low: exit is refused, reset reports an abort
    oth_rdy_n <= 0;
    repeat (3) @(posedge clk_i);
    expect_rd(8'h0c, 32'h40, 32'h0);
    st_e = 4'ha;
    run(4'hb, 21'h0, 16'h0);
    st_e = 4'h6;
    run(4'hc, 21'h0, 16'h0);
    give_verdict;
  end
endmodule
